// ===== inc/pdc_consts.svh
// Constants for the PLL divider counter configuration block
//
// How it works
// [R1] Reference divider is 14 bits; bits 13:8 from 0x012[5:0], reset zero.
// [R2] Reference divider bits 7:0 from 0x011, reset one, so divide by one.
// [R3] Swallow counter is 6 bits from 0x013[5:0], reset zero; bits 7:6 unused.
// [R4] Main feedback counter is 13 bits; bits 7:0 from 0x014, reset three.
// [R5] Main counter bits 12:8 from 0x015[4:0], reset zero; bits 7:5 unused.
// [R6] Bit 6 of 0x016 holds the reference divider in reset while set.
// [R7] Bit 5 of 0x016 holds swallow and main counters in reset while set.
// [R8] Bit 4 of 0x016 holds all three counters in reset while set.
// [R9] Bit 3 of 0x016 bypasses the main counter; only for fixed divide mode.
// [R10] A held counter restarts from its initial state once all holds clear.
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ==========================================================
// Register offsets
`define PDC_ADDR_REF_LO     13'h0011
`define PDC_ADDR_REF_HI     13'h0012
`define PDC_ADDR_SWALLOW    13'h0013
`define PDC_ADDR_FB_LO      13'h0014
`define PDC_ADDR_FB_HI      13'h0015
`define PDC_ADDR_CTL        13'h0016

// ==========================================================
// Reset values
`define PDC_RST_REF_LO      8'h01
`define PDC_RST_REF_HI      6'h00
`define PDC_RST_SWALLOW     6'h00
`define PDC_RST_FB_LO       8'h03
`define PDC_RST_FB_HI       5'h00
`define PDC_RST_CTL_BIT     1'h0

// ==========================================================
// Control register bit positions
`define PDC_BIT_RST_REF     6
`define PDC_BIT_RST_AB      5
`define PDC_BIT_RST_ALL     4
`define PDC_BIT_BYPASS      3

// ==========================================================
// Serial frame: 16 instruction bits then 8 data bits
`define PDC_LAST_INSTR_BIT  5'h0f
`define PDC_LAST_FRAME_BIT  5'h17
`define PDC_INSTR_RD_POS    15

`endif

// ===== inc/pdc_pkg.sv
// Types shared by the PLL divider counter configuration block
`default_nettype none
package pdc_pkg;

   // ==========================================================
   // Serial port states
   typedef enum logic [2:0] {
      PDC_SPI_IDLE  = 3'b000,
      PDC_SPI_INSTR = 3'b001,
      PDC_SPI_WDATA = 3'b010,
      PDC_SPI_RDATA = 3'b011,
      PDC_SPI_DONE  = 3'b100
   } pdc_spi_state_t;

endpackage
`default_nettype wire

// ===== inc/pdc_cnt_if.sv
// Carrier between the top level and one divider counter
`default_nettype none
interface pdc_cnt_if #(
   parameter int W = 14
);
   logic         tick;
   logic         hold;
   logic [W-1:0] div;
   logic         term;

   modport ctrl (output tick, output hold, output div, input term);
   modport cnt  (input tick, input hold, input div, output term);
endinterface
`default_nettype wire

// ===== design/pdc_sync.sv
// Two-stage synchroniser with edge detection for pin inputs
`default_nettype none
module pdc_sync #(
   parameter int W = 5
) (
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta;
   logic [W-1:0] stab;
   logic [W-1:0] last;

   // ==========================================================
   // One chain per bit; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               meta[i] <= 1'b0;
               stab[i] <= 1'b0;
               last[i] <= 1'b0;
            end else begin
               meta[i] <= din[i];
               stab[i] <= meta[i];
               last[i] <= stab[i];
            end
         end
         assign rise[i] = stab[i] & ~last[i];
         assign fall[i] = ~stab[i] & last[i];
      end
   endgenerate

   assign dout = stab;

endmodule
`default_nettype wire

// ===== design/pdc_div_counter.sv
// Programmable divider counter: one terminal pulse per div ticks
`default_nettype none
module pdc_div_counter #(
   parameter int W = 14
) (
   input  wire logic core_clk,
   input  wire logic rstn,
   pdc_cnt_if.cnt    port
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         term;
   logic         next_term;

   // ==========================================================
   // Count state; a setting of zero behaves as divide by one
   always_comb begin
      next_cnt  = cnt;
      next_term = 1'b0;
      if (port.hold) begin
         next_cnt = W'(1); // R10
      end else if (port.tick) begin
         if (cnt >= port.div) begin
            next_cnt  = W'(1);
            next_term = 1'b1;
         end else begin
            next_cnt = cnt + W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt  <= W'(1);
         term <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         term <= next_term;
      end
   end

   assign port.term = term;

endmodule
`default_nettype wire

// ===== design/pdc_top.sv
// Divider configuration registers, serial control port and loop counters
`default_nettype none
`include "pdc_consts.svh"
module pdc_top
   import pdc_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic ref_clk_in,
   input  wire logic presc_clk_in,
   input  wire logic spi_sclk,
   input  wire logic spi_csb_n,
   input  wire logic spi_sdi,
   output logic      spi_sdo,
   output logic      spi_sdo_oe,
   output logic      ref_div_out,
   output logic      fb_div_out,
   output logic      mod_sel_out
);

   // ==========================================================
   // Pin synchronisers
   localparam int SYN_REF   = 0;
   localparam int SYN_PRESC = 1;
   localparam int SYN_SCLK  = 2;
   localparam int SYN_CSB   = 3;
   localparam int SYN_SDI   = 4;

   logic [4:0] syn_q;
   logic [4:0] syn_rise;
   logic [4:0] syn_fall;

   pdc_sync #(
      .W (5)
   ) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .din      ({spi_sdi, spi_csb_n, spi_sclk, presc_clk_in, ref_clk_in}),
      .dout     (syn_q),
      .rise     (syn_rise),
      .fall     (syn_fall)
   );

   logic sclk_rise;
   logic sclk_fall;
   logic cs_idle;
   logic sdi;
   logic ref_tick;
   logic presc_tick;

   assign sclk_rise  = syn_rise[SYN_SCLK];
   assign sclk_fall  = syn_fall[SYN_SCLK];
   assign cs_idle    = syn_q[SYN_CSB];
   assign sdi        = syn_q[SYN_SDI];
   assign ref_tick   = syn_rise[SYN_REF];
   assign presc_tick = syn_rise[SYN_PRESC];

   // ==========================================================
   // Configuration registers
   logic [7:0] ref_lo;
   logic [5:0] ref_hi;
   logic [5:0] swallow;
   logic [7:0] fb_lo;
   logic [4:0] fb_hi;
   logic       rst_ref;
   logic       rst_ab;
   logic       rst_all;
   logic       b_bypass;

   logic [7:0] next_ref_lo;
   logic [5:0] next_ref_hi;
   logic [5:0] next_swallow;
   logic [7:0] next_fb_lo;
   logic [4:0] next_fb_hi;
   logic       next_rst_ref;
   logic       next_rst_ab;
   logic       next_rst_all;
   logic       next_b_bypass;

   logic        wr_en;
   logic [12:0] wr_addr;
   logic [7:0]  wr_data;

   // Unused and unimplemented bits read back as zero
   function automatic logic [7:0] reg_read(input logic [12:0] addr);
      logic [7:0] d;
      d = 8'h00;
      case (addr)
         `PDC_ADDR_REF_LO:  d = ref_lo;
         `PDC_ADDR_REF_HI:  d = {2'h0, ref_hi};
         `PDC_ADDR_SWALLOW: d = {2'h0, swallow};
         `PDC_ADDR_FB_LO:   d = fb_lo;
         `PDC_ADDR_FB_HI:   d = {3'h0, fb_hi};
         `PDC_ADDR_CTL:     d = {1'h0, rst_ref, rst_ab, rst_all, b_bypass, 3'h0};
         default:           d = 8'h00;
      endcase
      return d;
   endfunction

   always_comb begin
      next_ref_lo   = ref_lo;
      next_ref_hi   = ref_hi;
      next_swallow  = swallow;
      next_fb_lo    = fb_lo;
      next_fb_hi    = fb_hi;
      next_rst_ref  = rst_ref;
      next_rst_ab   = rst_ab;
      next_rst_all  = rst_all;
      next_b_bypass = b_bypass;
      if (wr_en) begin
         case (wr_addr)
            `PDC_ADDR_REF_LO: begin
               next_ref_lo = wr_data; // R2
            end
            `PDC_ADDR_REF_HI: begin
               next_ref_hi = wr_data[5:0]; // R1
            end
            `PDC_ADDR_SWALLOW: begin
               next_swallow = wr_data[5:0]; // R3
            end
            `PDC_ADDR_FB_LO: begin
               next_fb_lo = wr_data; // R4
            end
            `PDC_ADDR_FB_HI: begin
               next_fb_hi = wr_data[4:0]; // R5
            end
            `PDC_ADDR_CTL: begin
               next_rst_ref  = wr_data[`PDC_BIT_RST_REF]; // R6
               next_rst_ab   = wr_data[`PDC_BIT_RST_AB]; // R7
               next_rst_all  = wr_data[`PDC_BIT_RST_ALL]; // R8
               next_b_bypass = wr_data[`PDC_BIT_BYPASS]; // R9
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ref_lo   <= `PDC_RST_REF_LO; // R2
         ref_hi   <= `PDC_RST_REF_HI; // R1
         swallow  <= `PDC_RST_SWALLOW; // R3
         fb_lo    <= `PDC_RST_FB_LO; // R4
         fb_hi    <= `PDC_RST_FB_HI; // R5
         rst_ref  <= `PDC_RST_CTL_BIT;
         rst_ab   <= `PDC_RST_CTL_BIT;
         rst_all  <= `PDC_RST_CTL_BIT;
         b_bypass <= `PDC_RST_CTL_BIT;
      end else begin
         ref_lo   <= next_ref_lo;
         ref_hi   <= next_ref_hi;
         swallow  <= next_swallow;
         fb_lo    <= next_fb_lo;
         fb_hi    <= next_fb_hi;
         rst_ref  <= next_rst_ref;
         rst_ab   <= next_rst_ab;
         rst_all  <= next_rst_all;
         b_bypass <= next_b_bypass;
      end
   end

   // ==========================================================
   // Serial control port: one byte per frame, mode 0
   pdc_spi_state_t st;
   pdc_spi_state_t next_st;
   logic [4:0]     bit_cnt;
   logic [4:0]     next_bit_cnt;
   logic [23:0]    sh_in;
   logic [23:0]    next_sh_in;
   logic [23:0]    shifted;
   logic [7:0]     rd_sh;
   logic [7:0]     next_rd_sh;
   logic           next_sdo;
   logic           next_sdo_oe;

   assign shifted = {sh_in[22:0], sdi};
   assign wr_addr = shifted[20:8];
   assign wr_data = shifted[7:0];

   always_comb begin
      next_st      = st;
      next_bit_cnt = bit_cnt;
      next_sh_in   = sh_in;
      next_rd_sh   = rd_sh;
      next_sdo     = spi_sdo;
      next_sdo_oe  = spi_sdo_oe;
      wr_en        = 1'b0;
      if (cs_idle) begin
         // Deselect aborts any frame; a half-written byte is dropped
         next_st      = PDC_SPI_IDLE;
         next_bit_cnt = 5'h00;
         next_sdo     = 1'b0;
         next_sdo_oe  = 1'b0;
      end else begin
         unique case (st)
            PDC_SPI_IDLE: begin
               next_st      = PDC_SPI_INSTR;
               next_bit_cnt = 5'h00;
            end
            PDC_SPI_INSTR: begin
               if (sclk_rise) begin
                  next_sh_in   = shifted;
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == `PDC_LAST_INSTR_BIT) begin
                     if (shifted[`PDC_INSTR_RD_POS]) begin
                        // Read data is captured once the address is complete
                        next_rd_sh  = reg_read(shifted[12:0]);
                        next_sdo_oe = 1'b1;
                        next_st     = PDC_SPI_RDATA;
                     end else begin
                        next_st = PDC_SPI_WDATA;
                     end
                  end
               end
            end
            PDC_SPI_WDATA: begin
               if (sclk_rise) begin
                  next_sh_in   = shifted;
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == `PDC_LAST_FRAME_BIT) begin
                     wr_en   = 1'b1;
                     next_st = PDC_SPI_DONE;
                  end
               end
            end
            PDC_SPI_RDATA: begin
               if (sclk_fall) begin
                  next_sdo   = rd_sh[7];
                  next_rd_sh = {rd_sh[6:0], 1'b0};
               end
               if (sclk_rise) begin
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == `PDC_LAST_FRAME_BIT) begin
                     next_st = PDC_SPI_DONE;
                  end
               end
            end
            PDC_SPI_DONE: begin
               next_sdo_oe = 1'b0;
            end
            default: begin
               next_st = PDC_SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st         <= PDC_SPI_IDLE;
         bit_cnt    <= 5'h00;
         sh_in      <= 24'h000000;
         rd_sh      <= 8'h00;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         st         <= next_st;
         bit_cnt    <= next_bit_cnt;
         sh_in      <= next_sh_in;
         rd_sh      <= next_rd_sh;
         spi_sdo    <= next_sdo;
         spi_sdo_oe <= next_sdo_oe;
      end
   end

   // ==========================================================
   // Loop counters
   logic ref_hold;
   logic ab_hold;

   assign ref_hold = rst_ref | rst_all; // R6 R8
   assign ab_hold  = rst_ab | rst_all; // R7 R8

   pdc_cnt_if #(.W(14)) ref_if ();
   pdc_cnt_if #(.W(13)) fb_if ();

   assign ref_if.tick = ref_tick;
   assign ref_if.hold = ref_hold; // R10
   assign ref_if.div  = {ref_hi, ref_lo}; // R1 R2
   assign fb_if.tick  = presc_tick;
   assign fb_if.hold  = ab_hold | b_bypass; // R10
   assign fb_if.div   = {fb_hi, fb_lo}; // R4 R5

   pdc_div_counter #(
      .W (14)
   ) u_ref_cnt (
      .core_clk (core_clk),
      .rstn     (rstn),
      .port     (ref_if.cnt)
   );

   pdc_div_counter #(
      .W (13)
   ) u_fb_cnt (
      .core_clk (core_clk),
      .rstn     (rstn),
      .port     (fb_if.cnt)
   );

   // Swallow count: prescaler runs at the higher modulus for the
   // first swallow ticks of each main counter cycle
   logic [5:0] a_cnt;
   logic [5:0] next_a_cnt;
   logic       next_ref_div_out;
   logic       next_fb_div_out;
   logic       next_mod_sel;

   always_comb begin
      next_a_cnt = a_cnt;
      if (ab_hold || fb_if.term) begin
         next_a_cnt = 6'h00; // R10
      end else if (presc_tick && (a_cnt < swallow)) begin
         next_a_cnt = a_cnt + 6'h01; // R3
      end
      next_ref_div_out = ref_if.term;
      // Bypass passes every prescaler rising edge while ab_hold is clear; valid in fixed divide mode only
      if (b_bypass) begin
         next_fb_div_out = presc_tick & ~ab_hold; // R9
         next_mod_sel    = 1'b0;
      end else begin
         next_fb_div_out = fb_if.term;
         next_mod_sel    = ~ab_hold & (next_a_cnt < swallow); // R7
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         a_cnt       <= 6'h00;
         ref_div_out <= 1'b0;
         fb_div_out  <= 1'b0;
         mod_sel_out <= 1'b0;
      end else begin
         a_cnt       <= next_a_cnt;
         ref_div_out <= next_ref_div_out;
         fb_div_out  <= next_fb_div_out;
         mod_sel_out <= next_mod_sel;
      end
   end

endmodule
`default_nettype wire

// ===== bench/pdc_top_asserts.sv
// Port-level checks for the divider configuration block
`default_nettype none
module pdc_top_asserts (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ref_clk_in,
   input wire logic presc_clk_in,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   input wire logic ref_div_out,
   input wire logic fb_div_out,
   input wire logic mod_sel_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========
   // Cycles since the last pin edge, saturating so idle pins stay visible
   logic [2:0] prev;
   logic [3:0] age_ref;
   logic [3:0] age_presc;
   logic [3:0] age_fall;

   function automatic logic [3:0] age(logic hit, logic [3:0] a);
      return hit ? 4'h0 : a + {3'h0, a != 4'hf};
   endfunction

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prev      <= 3'h0;
         age_ref   <= 4'hf;
         age_presc <= 4'hf;
         age_fall  <= 4'hf;
      end else begin
         prev      <= {ref_clk_in, presc_clk_in, spi_sclk};
         age_ref   <= age(ref_clk_in && !prev[2], age_ref);
         age_presc <= age(presc_clk_in && !prev[1], age_presc);
         age_fall  <= age(!spi_sclk && prev[0], age_fall);
      end
   end

   // ==========
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_read_open;
      $rose(spi_sdo_oe);
   endsequence
   sequence s_deselected;
      spi_csb_n [*8];
   endsequence

   property p_reset_quiet;
      $rose(rstn) |-> !ref_div_out && !fb_div_out && !mod_sel_out && !spi_sdo_oe;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("output active after reset");
   property p_ref_single;
      ref_div_out |=> !ref_div_out;
   endproperty
   a_ref_single: assert property (p_ref_single)
      else $error("ref pulse too long");
   property p_fb_single;
      fb_div_out |=> !fb_div_out;
   endproperty
   a_fb_single: assert property (p_fb_single)
      else $error("fb pulse too long");
   property p_ref_cause;
      ref_div_out |-> age_ref <= 4'h8;
   endproperty
   a_ref_cause: assert property (p_ref_cause)
      else $error("ref pulse without ref edge");
   property p_fb_cause;
      fb_div_out |-> age_presc <= 4'h8;
   endproperty
   a_fb_cause: assert property (p_fb_cause)
      else $error("fb pulse without prescaler edge");
   property p_read_hold;
      s_read_open |-> spi_sdo_oe [*8];
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read drive too short");
   property p_read_selected;
      s_read_open |-> !spi_csb_n;
   endproperty
   a_read_selected: assert property (p_read_selected)
      else $error("read drive while deselected");
   property p_idle_quiet;
      s_deselected |-> !spi_sdo_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("sdo driven while idle");
   property p_sdo_timing;
      spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo) |-> age_fall <= 4'h7;
   endproperty
   a_sdo_timing: assert property (p_sdo_timing)
      else $error("sdo changed away from sclk fall");
endmodule

bind pdc_top pdc_top_asserts u_asserts (
   .core_clk, .rstn, .ref_clk_in, .presc_clk_in, .spi_sclk, .spi_csb_n,
   .spi_sdi, .spi_sdo, .spi_sdo_oe, .ref_div_out, .fb_div_out, .mod_sel_out
);
`default_nettype wire

// ===== bench/pdc_top_tb.sv
// Self-checking bench for the divider configuration block
`default_nettype none
`include "pdc_consts.svh"
module pdc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PH = 6;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        ref_clk_in = 1'b0;
   logic        presc_clk_in = 1'b0;
   logic        spi_sclk = 1'b0;
   logic        spi_csb_n = 1'b1;
   logic        spi_sdi = 1'b0;
   logic        spi_sdo;
   logic        spi_sdo_oe;
   logic        ref_div_out;
   logic        fb_div_out;
   logic        mod_sel_out;
   logic [15:0] lfsr = 16'h0031;
   logic [15:0] n_ref = 16'h0000;
   logic [15:0] n_fb = 16'h0000;
   logic [15:0] n_mod = 16'h0000;
   logic        mod_prev = 1'b0;
   logic [15:0] mod_q[$];
   logic [15:0] mod_tab[5] = '{16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0005};
   logic [7:0]  rd_sh = 8'h00;
   logic [7:0]  rd_q[$];
   logic [31:0] cnt_q[$];
   logic [7:0]  rst_tab[6] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
   logic [7:0]  msk[5] = '{8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f};
   logic [7:0]  ctl_tab[5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00};
   logic [31:0] exp_tab[5] = '{32'h4, 32'h60000, 32'h0, 32'h6000c, 32'h60004};
   int          nb = 0;
   int          err_count = 0;
   int          comparisons = 0;
   event        burst_end;

   always #5 core_clk = ~core_clk;

   pdc_top u_dut (
      .core_clk, .rstn, .ref_clk_in, .presc_clk_in, .spi_sclk, .spi_csb_n,
      .spi_sdi, .spi_sdo, .spi_sdo_oe, .ref_div_out, .fb_div_out, .mod_sel_out
   );

   // ==========
   // Checking and closing
   task automatic check_byte(logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic check_count(logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // ==========
   // Drivers
   task automatic wait_n(int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Slow sclk phases so the synchronised port never misses an edge
   task automatic frame(logic rd, logic [12:0] a, logic [7:0] d);
      logic [23:0] w;
      w = {rd, 2'b00, a, d};
      spi_csb_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = w[i];
         wait_n(PH);
         spi_sclk = 1'b1;
         wait_n(PH);
         spi_sclk = 1'b0;
      end
      wait_n(PH);
      spi_csb_n = 1'b1;
      wait_n(PH);
   endtask

   task automatic spi_read(logic [12:0] a, logic [7:0] e);
      rd_q.push_back(e);
      frame(1'b1, a, 8'h00);
   endtask

   task automatic set_div(logic [13:0] r, logic [12:0] b);
      frame(1'b0, `PDC_ADDR_REF_LO, r[7:0]);
      frame(1'b0, `PDC_ADDR_REF_HI, {2'b00, r[13:8]});
      frame(1'b0, `PDC_ADDR_FB_LO, b[7:0]);
      frame(1'b0, `PDC_ADDR_FB_HI, {3'b000, b[12:8]});
   endtask

   // Holding all counters first makes every burst start from a known count
   task automatic burst(logic [7:0] ctl, int nr, int np, logic [31:0] e, logic [15:0] em);
      frame(1'b0, `PDC_ADDR_CTL, 8'h10);
      // Swallow phase starts are counted from the release of the holds only
      n_mod = 16'h0000;
      frame(1'b0, `PDC_ADDR_CTL, ctl);
      for (int i = 0; i < nr || i < np; i++) begin
         ref_clk_in = i < nr;
         presc_clk_in = i < np;
         wait_n(2);
         ref_clk_in = 1'b0;
         presc_clk_in = 1'b0;
         wait_n(2);
      end
      wait_n(10);
      cnt_q.push_back(e);
      mod_q.push_back(em);
      -> burst_end;
      wait_n(1);
   endtask

   // ==========
   // Monitors
   always @(posedge spi_sclk) begin
      if (spi_sdo_oe === 1'b1) begin
         rd_sh = {rd_sh[6:0], spi_sdo};
         nb++;
         if (nb == 8) begin
            nb = 0;
            check_byte(rd_q.pop_front(), rd_sh);
         end
      end
   end

   always @(negedge core_clk) begin
      n_ref = n_ref + {15'h0, ref_div_out === 1'b1};
      n_fb = n_fb + {15'h0, fb_div_out === 1'b1};
      n_mod = n_mod + {15'h0, mod_sel_out === 1'b1 && mod_prev !== 1'b1};
      mod_prev = mod_sel_out;
   end

   always @(burst_end) begin
      check_count(cnt_q.pop_front(), {n_ref, n_fb});
      check_count({16'h0000, mod_q.pop_front()}, {16'h0000, n_mod});
      n_ref = 16'h0000;
      n_fb = 16'h0000;
   end

   // ==========
   // Scenarios
   initial begin
      wait_n(3);
      rstn = 1'b1;
      wait_n(4);
      for (int i = 0; i < 6; i++) begin
         spi_read(13'(i + 17), rst_tab[i]);
      end
      burst(8'h00, 5, 9, 32'h0005_0003, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsr_next(lfsr);
         frame(1'b0, 13'(i + 17), lfsr[7:0]);
         spi_read(13'(i + 17), lfsr[7:0] & msk[i]);
      end
      frame(1'b0, `PDC_ADDR_CTL, 8'hf8);
      spi_read(`PDC_ADDR_CTL, 8'h78);
      frame(1'b0, 13'h0017, 8'h5a);
      spi_read(13'h0017, 8'h00);
      spi_read(13'h0010, 8'h00);
      set_div(14'h0102, 13'h0102);
      burst(8'h00, 516, 516, 32'h0002_0002, 16'h0003);
      // Second reset in mid-run: written fields must fall back to their defaults
      rstn = 1'b0;
      wait_n(3);
      rstn = 1'b1;
      wait_n(4);
      for (int i = 0; i < 6; i++) begin
         spi_read(13'(i + 17), rst_tab[i]);
      end
      set_div(14'h0002, 13'h0003);
      frame(1'b0, `PDC_ADDR_SWALLOW, 8'h01);
      for (int i = 0; i < 5; i++) begin
         burst(ctl_tab[i], 12, 12, exp_tab[i], mod_tab[i]);
      end
      wait_n(20);
      tally_and_finish();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
